/* src/temp_fault_defines.svh */
// Command codes, field positions, reset values and timing for the temperature fault block
`ifndef TEMP_FAULT_DEFINES_SVH
`define TEMP_FAULT_DEFINES_SVH

// Command codes
`define CMD_CLEAR_FAULTS      8'h03
`define CMD_EXT_OT_RESPONSE   8'h50
`define CMD_EXT_UT_RESPONSE   8'h54
`define CMD_INT_OT_RESPONSE   8'hd6
`define CMD_STATUS_SUMMARY    8'h78
`define CMD_STATUS_WORD       8'h79
`define CMD_STATUS_TEMP       8'h7d
`define CMD_STATUS_COMM       8'h7e
`define CMD_STATUS_VENDOR     8'h80

// Reset values
`define EXT_RESPONSE_RESET    8'hb8
`define INT_RESPONSE_RESET    8'hc0

// Response and retry encodings
`define RESP_CONTINUE         2'h0
`define RESP_UNSUPPORTED      2'h1
`define RESP_SHUTDOWN         2'h2
`define RESP_HOLD_WHILE       2'h3
`define RETRY_NONE            3'h0
`define RETRY_FOREVER         3'h7

// Status bit positions
`define SUMMARY_COMM_BIT      1
`define SUMMARY_TEMP_BIT      2
`define WORD_VENDOR_BIT       12
`define TEMP_OT_BIT           7
`define TEMP_UT_BIT           4
`define COMM_INVALID_BIT      6
`define VENDOR_OT_BIT         6

// Timing
`define CLK_KHZ               20000
`define ADC_CYCLE_MS          120
`define ADC_CYCLE_CYCLES      (`ADC_CYCLE_MS * `CLK_KHZ)

`endif

/* src/temp_fault_pkg.sv */
// Types for the temperature fault response block
`default_nettype none
package temp_fault_pkg;

	typedef struct packed {
		logic [1:0] resp;
		logic [2:0] retry;
		logic [2:0] delay;
	} response_t;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       page;
		logic [7:0] code;
		logic [7:0] data;
	} command_t;

	typedef struct packed {
		logic ext_ot;
		logic ext_ut;
		logic int_ot;
	} fault_mask_t;

endpackage : temp_fault_pkg
`default_nettype wire

/* src/temp_fault_response.sv */
// Temperature fault response registers, flags, alert and output shutdown control
// Notes on behaviour
// - Internal overtemp sets vendor summary in status word
// - Internal overtemp sets vendor-status overtemp flag
// - Every temperature fault alerts unless masked
// - Response registers move as one data byte
// - Internal response codes 00, 01 raise comm fault
// - Code 10: disable at once, then retry field
// - Code 11: off while fault, resume after
// - Retry 000: stay off until cleared
// - Internal retry 001-111 raise comm fault
// - Internal delay field bits 2:0 ignored
// - Flags clear by clear command, restart, reset
// - External overtemp response at 0x50, default b8
// - External undertemp response at 0x54, default b8
// - External overtemp sets temperature summary and flag
// - External faults sampled once per ADC cycle
// - Internal response shared, default c0
// - External code 00 keeps output running
// - External retry 111 restarts on each interval
`include "temp_fault_defines.svh"
`default_nettype none
module temp_fault_response #(
	parameter int ADC_CYCLE = `ADC_CYCLE_CYCLES
) (
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire temp_fault_pkg::command_t    cmd,
	input  wire logic                        int_ot_fault,
	input  wire logic [1:0]                  ext_ot_fault,
	input  wire logic [1:0]                  ext_ut_fault,
	input  wire logic [1:0]                  channel_run_pin,
	input  wire logic [1:0]                  retry_interval_tick,
	input  wire temp_fault_pkg::fault_mask_t alert_mask,
	output logic [1:0]                       chan_enable_r,
	output logic                             alert_n_r,
	output logic                             rsp_valid_r,
	output logic [15:0]                      rsp_data_r,
	output logic                             comm_fault_r
);

	localparam int CNT_W = $clog2(ADC_CYCLE + 1);
	localparam logic [CNT_W-1:0] ADC_LAST = CNT_W'(ADC_CYCLE - 1);

	// Accept check for an external response byte
	function automatic logic ext_resp_ok(input logic [7:0] value);
		temp_fault_pkg::response_t r;
		r = value;
		// Codes 01 and 11 are refused
		ext_resp_ok = r.resp == `RESP_CONTINUE || r.resp == `RESP_SHUTDOWN;
	endfunction : ext_resp_ok

	// Accept check for the internal response byte; delay bits ignored
	function automatic logic int_resp_ok(input logic [7:0] value);
		temp_fault_pkg::response_t r;
		r = value;
		int_resp_ok = (r.resp == `RESP_SHUTDOWN || r.resp == `RESP_HOLD_WHILE)
			&& r.retry == `RETRY_NONE;
	endfunction : int_resp_ok

	temp_fault_pkg::response_t ot_resp_r [2];
	temp_fault_pkg::response_t ut_resp_r [2];
	temp_fault_pkg::response_t int_resp_r;

	logic [CNT_W-1:0] adc_cnt_r;
	logic [1:0]       ot_smp_r;
	logic [1:0]       ut_smp_r;
	logic [1:0]       ot_flag_r;
	logic [1:0]       ut_flag_r;
	logic             int_flag_r;
	logic [1:0]       latch_int_r;
	logic [1:0]       latch_ot_r;
	logic [1:0]       latch_ut_r;
	logic [1:0]       run_prev_r;

	// Command decode
	wire wr          = cmd.valid && cmd.write;
	wire rd          = cmd.valid && !cmd.write;
	wire wr_ot       = wr && cmd.code == `CMD_EXT_OT_RESPONSE;
	wire wr_ut       = wr && cmd.code == `CMD_EXT_UT_RESPONSE;
	wire wr_int      = wr && cmd.code == `CMD_INT_OT_RESPONSE;
	wire clear_cmd   = wr && cmd.code == `CMD_CLEAR_FAULTS;
	wire ext_good    = ext_resp_ok(cmd.data);
	wire int_good    = int_resp_ok(cmd.data);
	wire bad_write   = ((wr_ot || wr_ut) && !ext_good) || (wr_int && !int_good);
	wire adc_tick    = adc_cnt_r == ADC_LAST;
	// A rising run request restarts the channel
	wire [1:0] restart = channel_run_pin & ~run_prev_r;
	wire [1:0] clr_ch  = restart | {2{clear_cmd}};
	wire clr_int     = clear_cmd || (|restart);

	// Fault responses per channel
	// Internal fault acts on both channels
	wire int_trip    = int_ot_fault && int_resp_r.resp == `RESP_SHUTDOWN;
	wire int_hold    = int_ot_fault && int_resp_r.resp == `RESP_HOLD_WHILE;
	wire [1:0] ot_trip;
	wire [1:0] ut_trip;
	wire [1:0] ot_retry;
	wire [1:0] ut_retry;
	wire [1:0] enable_nxt;
	wire [1:0] ot_flag_nxt;
	wire [1:0] ut_flag_nxt;
	wire [1:0] latch_int_nxt;
	wire [1:0] latch_ot_nxt;
	wire [1:0] latch_ut_nxt;

	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_ch
			// Code 00 never trips, so the output keeps running
			assign ot_trip[c] = ot_smp_r[c] && ot_resp_r[c].resp == `RESP_SHUTDOWN;
			assign ut_trip[c] = ut_smp_r[c] && ut_resp_r[c].resp == `RESP_SHUTDOWN;
			assign ot_retry[c] = retry_interval_tick[c]
				&& ot_resp_r[c].retry == `RETRY_FOREVER;
			assign ut_retry[c] = retry_interval_tick[c]
				&& ut_resp_r[c].retry == `RETRY_FOREVER;
			// Trip wins over clear or retry in the same cycle
			assign latch_int_nxt[c] = int_trip || (latch_int_r[c] && !clr_ch[c]);
			assign latch_ot_nxt[c]  = ot_trip[c]
				|| (latch_ot_r[c] && !clr_ch[c] && !ot_retry[c]);
			assign latch_ut_nxt[c]  = ut_trip[c]
				|| (latch_ut_r[c] && !clr_ch[c] && !ut_retry[c]);
			assign enable_nxt[c] = channel_run_pin[c] && !int_hold && !latch_int_nxt[c]
				&& !latch_ot_nxt[c] && !latch_ut_nxt[c];
			assign ot_flag_nxt[c] = ot_smp_r[c] || (ot_flag_r[c] && !clr_ch[c]);
			assign ut_flag_nxt[c] = ut_smp_r[c] || (ut_flag_r[c] && !clr_ch[c]);
		end
	endgenerate

	wire int_flag_nxt  = int_ot_fault || (int_flag_r && !clr_int);
	wire comm_nxt      = bad_write || (comm_fault_r && !clear_cmd);
	// Comm fault alerts too and cannot be masked
	wire alert_any     = (|ot_flag_nxt && !alert_mask.ext_ot)
		|| (|ut_flag_nxt && !alert_mask.ext_ut)
		|| (int_flag_nxt && !alert_mask.int_ot) || comm_nxt;

	// Places one status flag at its bit of a 16-bit view
	function automatic logic [15:0] flag_at(input logic value, input int pos);
		flag_at = 16'(value) << pos;
	endfunction : flag_at

	// Status views of the addressed page
	wire             pg        = cmd.page;
	wire             temp_any  = ot_flag_r[pg] || ut_flag_r[pg];
	wire             ot_pg     = ot_flag_r[pg];
	wire             ut_pg     = ut_flag_r[pg];
	wire [15:0]      sum_temp  = flag_at(temp_any, `SUMMARY_TEMP_BIT);
	wire [15:0]      sum_comm  = flag_at(comm_fault_r, `SUMMARY_COMM_BIT);
	wire [15:0]      summary_v = sum_temp | sum_comm;
	wire [15:0]      word_v    = summary_v | flag_at(int_flag_r, `WORD_VENDOR_BIT);
	wire [15:0]      temp_ot_v = flag_at(ot_pg, `TEMP_OT_BIT);
	wire [15:0]      temp_ut_v = flag_at(ut_pg, `TEMP_UT_BIT);
	wire [15:0]      temp_v    = temp_ot_v | temp_ut_v;
	wire [15:0]      comm_v    = flag_at(comm_fault_r, `COMM_INVALID_BIT);
	wire [15:0]      vendor_v  = flag_at(int_flag_r, `VENDOR_OT_BIT);

	logic [15:0] rd_mux;
	always_comb
	begin
		case (cmd.code)
			`CMD_EXT_OT_RESPONSE: rd_mux = {8'h00, ot_resp_r[pg]};
			`CMD_EXT_UT_RESPONSE: rd_mux = {8'h00, ut_resp_r[pg]};
			`CMD_INT_OT_RESPONSE: rd_mux = {8'h00, int_resp_r};
			`CMD_STATUS_SUMMARY:  rd_mux = {8'h00, summary_v[7:0]};
			`CMD_STATUS_WORD:     rd_mux = word_v;
			`CMD_STATUS_TEMP:     rd_mux = temp_v;
			`CMD_STATUS_COMM:     rd_mux = comm_v;
			`CMD_STATUS_VENDOR:   rd_mux = vendor_v;
			default:              rd_mux = 16'h0000;
		endcase
	end

	// Read data holds until the next read
	wire [15:0] rd_data_nxt = rd ? rd_mux : rsp_data_r;

	// External response registers; rejected writes are not stored
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ot_resp_r[0] <= `EXT_RESPONSE_RESET;
			ot_resp_r[1] <= `EXT_RESPONSE_RESET;
			ut_resp_r[0] <= `EXT_RESPONSE_RESET;
			ut_resp_r[1] <= `EXT_RESPONSE_RESET;
		end
		else
		begin
			if (wr_ot && ext_good)
				ot_resp_r[pg] <= cmd.data;
			if (wr_ut && ext_good)
				ut_resp_r[pg] <= cmd.data;
		end
	end

	// Shared internal response; only supported codes are kept
	always_ff @(posedge clk)
	begin
		if (reset)
			int_resp_r <= `INT_RESPONSE_RESET;
		else if (wr_int && int_good)
			int_resp_r <= cmd.data;
	end

	// ADC measurement cycle sampling of external sensors
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			adc_cnt_r <= '0;
			ot_smp_r  <= 2'h0;
			ut_smp_r  <= 2'h0;
		end
		else
		begin
			adc_cnt_r <= adc_tick ? '0 : adc_cnt_r + 1'b1;
			if (adc_tick)
			begin
				ot_smp_r <= ext_ot_fault;
				ut_smp_r <= ext_ut_fault;
			end
		end
	end

	// Sticky fault flags
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ot_flag_r  <= 2'h0;
			ut_flag_r  <= 2'h0;
			int_flag_r <= 1'b0;
		end
		else
		begin
			ot_flag_r  <= ot_flag_nxt;
			ut_flag_r  <= ut_flag_nxt;
			int_flag_r <= int_flag_nxt;
		end
	end

	// Shutdown latches per channel and cause
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			latch_int_r <= 2'h0;
			latch_ot_r  <= 2'h0;
			latch_ut_r  <= 2'h0;
		end
		else
		begin
			latch_int_r <= latch_int_nxt;
			latch_ot_r  <= latch_ot_nxt;
			latch_ut_r  <= latch_ut_nxt;
		end
	end

	// Run request history and output enables
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			run_prev_r    <= 2'h0;
			chan_enable_r <= 2'h0;
		end
		else
		begin
			run_prev_r    <= channel_run_pin;
			chan_enable_r <= enable_nxt;
		end
	end

	// Communication fault and alert line
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			comm_fault_r <= 1'b0;
			alert_n_r    <= 1'b1;
		end
		else
		begin
			comm_fault_r <= comm_nxt;
			alert_n_r    <= !alert_any;
		end
	end

	// Read answer, one cycle after the command
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 16'h0000;
		end
		else
		begin
			rsp_valid_r <= rd;
			rsp_data_r  <= rd_data_nxt;
		end
	end

endmodule : temp_fault_response
`default_nettype wire

/* tb/temp_fault_host.sv */
// Host model issuing register commands to the block
`default_nettype none
module temp_fault_host (
	input	wire logic			clk,
	input	wire logic			rsp_valid_r,
	input	wire logic [15:0]		rsp_data_r,
	output	var temp_fault_pkg::command_t	cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial cmd = '0;
	// One data byte per command; lines scrambled once released
	task xfer(input logic w, input logic p, input logic [7:0] c, input logic [7:0] d);
		@(negedge clk);
		cmd <= {1'h1, w, p, c, d};
		@(negedge clk);
		cmd <= {1'h0, ~w, ~p, ~c, ~d};
	endtask : xfer
	task rd(input logic p, input logic [7:0] c, output logic [15:0] d);
		xfer(1'h0, p, c, 8'h00);
		// Answer stands in the cycle after the command
		d = rsp_valid_r ? rsp_data_r : 16'hdead;
	endtask : rd
endmodule : temp_fault_host
`default_nettype wire

/* tb/temp_fault_response_asserts.sv */
// Checker bound to the temperature fault response block
`include "temp_fault_defines.svh"
`default_nettype none
module temp_fault_response_asserts (
	input	wire logic				clk,
	input	wire logic				reset,
	input	wire temp_fault_pkg::command_t		cmd,
	input	wire logic				int_ot_fault,
	input	wire temp_fault_pkg::fault_mask_t	alert_mask,
	input	wire logic [1:0]			chan_enable_r,
	input	wire logic				alert_n_r,
	input	wire logic				rsp_valid_r,
	input	wire logic				comm_fault_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic rd = cmd.valid && !cmd.write;
	wire logic iw = cmd.valid && cmd.write && cmd.code == `CMD_INT_OT_RESPONSE;
	wire logic clr = cmd.valid && cmd.write && cmd.code == `CMD_CLEAR_FAULTS;
	wire logic clr_any = clr || reset;
	sequence comm_held;
		comm_fault_r [*2];
	endsequence
	AST_RD_ANS: assert property (rd |=> rsp_valid_r)
		else $error("read not answered");
	AST_RD_ONE: assert property (!rd |=> !rsp_valid_r)
		else $error("answer without read");
	AST_INT_OFF: assert property (int_ot_fault |=> chan_enable_r == 2'h0)
		else $error("output on during internal fault");
	AST_INT_ALERT: assert property (int_ot_fault && !alert_mask.int_ot |=> !alert_n_r)
		else $error("internal fault not alerted");
	AST_BAD_RESP: assert property (iw && !cmd.data[7] |=> comm_fault_r)
		else $error("bad response code accepted");
	AST_BAD_RETRY: assert property (iw && cmd.data[5:3] != 3'h0 |=> comm_fault_r)
		else $error("bad retry code accepted");
	AST_COMM_ALERT: assert property (comm_held |-> !alert_n_r)
		else $error("comm fault not alerted");
	AST_COMM_STICKY: assert property ($fell(comm_fault_r) |-> $past(clr_any))
		else $error("comm fault cleared without cause");
endmodule : temp_fault_response_asserts
bind temp_fault_response temp_fault_response_asserts i_chk (.clk(clk), .reset(reset),
	.cmd(cmd), .int_ot_fault(int_ot_fault), .alert_mask(alert_mask),
	.chan_enable_r(chan_enable_r), .alert_n_r(alert_n_r), .rsp_valid_r(rsp_valid_r),
	.comm_fault_r(comm_fault_r));
`default_nettype wire

/* tb/temp_fault_response_tb_top.sv */
// Self-checking bench for the temperature fault response block
`default_nettype none
module temp_fault_response_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic wr; logic [7:0] c; logic p; logic [7:0] w, e; logic f;} row_t;
	logic				clk = 1'h0, reset = 1'h1, int_ot = 1'h0, alert_n, rsp_valid, comm;
	logic [1:0]			ext_ot = 2'h0, ext_ut = 2'h0, run = 2'h0, tick = 2'h0, en;
	logic [15:0]			rdat, d;
	temp_fault_pkg::command_t	cmd;
	temp_fault_pkg::fault_mask_t	mask = 3'h0;
	int				failures = 0, n_checks = 0;
	row_t rows [10] = '{'{1'h0, 8'h50, 1'h0, 8'h00, 8'hb8, 1'h0}, '{1'h0, 8'h54, 1'h1, 8'h00,
		8'hb8, 1'h0}, '{1'h0, 8'hd6, 1'h0, 8'h00, 8'hc0, 1'h0}, '{1'h1, 8'h50, 1'h0, 8'h80,
		8'h80, 1'h0}, '{1'h1, 8'h54, 1'h1, 8'h00, 8'h00, 1'h0}, '{1'h1, 8'h50, 1'h0, 8'h40,
		8'h80, 1'h1}, '{1'h1, 8'hd6, 1'h0, 8'h87, 8'h87, 1'h0}, '{1'h1, 8'hd6, 1'h0, 8'h40,
		8'h87, 1'h1}, '{1'h1, 8'hd6, 1'h0, 8'h88, 8'h87, 1'h1}, '{1'h1, 8'hd6, 1'h0, 8'h00,
		8'h87, 1'h1}};
	always #25 clk = ~clk;
	temp_fault_host i_host (.clk(clk), .rsp_valid_r(rsp_valid), .rsp_data_r(rdat), .cmd(cmd));
	temp_fault_response #(.ADC_CYCLE(16)) i_dut (.clk(clk), .reset(reset), .cmd(cmd),
		.int_ot_fault(int_ot), .ext_ot_fault(ext_ot), .ext_ut_fault(ext_ut),
		.channel_run_pin(run), .retry_interval_tick(tick), .alert_mask(mask),
		.chan_enable_r(en), .alert_n_r(alert_n), .rsp_valid_r(rsp_valid), .rsp_data_r(rdat),
		.comm_fault_r(comm));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks=%0d mismatches=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task wr(input logic p, input logic [7:0] c, input logic [7:0] w);
		i_host.xfer(1'h1, p, c, w);
	endtask : wr
	task pause(input int n);
		repeat (n) @(negedge clk);
	endtask : pause
	initial
	begin
		pause(16);
		chk({13'h0, comm, en}, 16'h0000);
		reset = 1'h0;
		run = 2'h3;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr(rows[i].p, rows[i].c, rows[i].w);
			i_host.rd(rows[i].p, rows[i].c, d);
			chk(d, {8'h00, rows[i].e});
			chk({15'h0, comm}, {15'h0, rows[i].f});
			wr(1'h0, 8'h03, 8'h00);
		end
		// Shutdown with no retry, then flag reads and clear
		int_ot = 1'h1;
		pause(4);
		int_ot = 1'h0;
		pause(4);
		chk({13'h0, alert_n, en}, 16'h0000);
		i_host.rd(1'h0, 8'h80, d);
		chk(d, 16'h0040);
		i_host.rd(1'h1, 8'h79, d);
		chk(d, 16'h1000);
		wr(1'h0, 8'h03, 8'h00);
		pause(3);
		chk({13'h0, alert_n, en}, 16'h0007);
		// Off only while the fault lasts
		wr(1'h0, 8'hd6, 8'hc0);
		int_ot = 1'h1;
		pause(3);
		chk({14'h0, en}, 16'h0000);
		int_ot = 1'h0;
		pause(3);
		chk({14'h0, en}, 16'h0003);
		wr(1'h0, 8'h03, 8'h00);
		// External faults: channel 0 shuts down, channel 1 keeps running
		ext_ot = 2'h1;
		ext_ut = 2'h2;
		pause(40);
		chk({13'h0, alert_n, en}, 16'h0002);
		i_host.rd(1'h0, 8'h7d, d);
		chk(d, 16'h0080);
		i_host.rd(1'h1, 8'h7d, d);
		chk(d, 16'h0010);
		i_host.rd(1'h0, 8'h78, d);
		chk(d, 16'h0004);
		// Continuous retry releases the latched channel
		wr(1'h0, 8'h50, 8'hb8);
		ext_ot = 2'h0;
		pause(40);
		chk({14'h0, en}, 16'h0002);
		tick = 2'h1;
		pause(1);
		tick = 2'h0;
		pause(3);
		chk({14'h0, en}, 16'h0003);
		run = 2'h0;
		pause(1);
		run = 2'h3;
		pause(3);
		i_host.rd(1'h0, 8'h7d, d);
		chk(d, 16'h0000);
		// Masked faults keep the alert line released
		mask = 3'h7;
		wr(1'h0, 8'h03, 8'h00);
		int_ot = 1'h1;
		pause(3);
		chk({13'h0, alert_n, en}, 16'h0004);
		mask = 3'h0;
		int_ot = 1'h0;
		pause(3);
		chk({13'h0, alert_n, en}, 16'h0003);
		// Refused external code shows in comm status
		wr(1'h0, 8'h54, 8'hc0);
		i_host.rd(1'h0, 8'h7e, d);
		chk(d, 16'h0040);
		i_host.rd(1'h0, 8'h54, d);
		chk(d, 16'h00b8);
		tally_and_finish();
	end
	initial
	begin
		repeat (3000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule : temp_fault_response_tb_top
`default_nettype wire
